// File: common/io_space_pkg.sv
package io_space_pkg;

  localparam int REG_W = 8;
  localparam int IO_SPACE_SIZE = 64;
  localparam int NUM_PORTS = 7;

  // Address windows seen by the core.
  localparam logic [7:0] BIT_OP_LAST = 8'h1F;
  localparam logic [7:0] SHORT_LAST = 8'h3F;
  localparam logic [7:0] DATA_IO_OFFSET = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam logic [7:0] EXT_LAST = 8'hFF;

  // I/O addresses of the implemented registers.
  localparam logic [5:0] PORT_A_INPUT_PINS = 6'h00;
  localparam logic [5:0] PORT_A_DIRECTION = 6'h01;
  localparam logic [5:0] PORT_A_OUTPUT = 6'h02;
  localparam logic [5:0] PORT_B_INPUT_PINS = 6'h03;
  localparam logic [5:0] PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] PORT_C_INPUT_PINS = 6'h06;
  localparam logic [5:0] PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] PORT_D_INPUT_PINS = 6'h09;
  localparam logic [5:0] PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] PORT_E_INPUT_PINS = 6'h0C;
  localparam logic [5:0] PORT_E_DIRECTION = 6'h0D;
  localparam logic [5:0] PORT_E_OUTPUT = 6'h0E;
  localparam logic [5:0] PORT_F_INPUT_PINS = 6'h0F;
  localparam logic [5:0] PORT_F_DIRECTION = 6'h10;
  localparam logic [5:0] PORT_F_OUTPUT = 6'h11;
  localparam logic [5:0] PORT_G_INPUT_PINS = 6'h12;
  localparam logic [5:0] PORT_G_DIRECTION = 6'h13;
  localparam logic [5:0] PORT_G_OUTPUT = 6'h14;
  localparam logic [5:0] TIMER_ZERO_FLAGS = 6'h15;
  localparam logic [5:0] TIMER_ONE_FLAGS = 6'h16;
  localparam logic [5:0] TIMER_TWO_FLAGS = 6'h17;
  localparam logic [5:0] EXTERNAL_IRQ_FLAGS = 6'h1C;
  localparam logic [5:0] EXTERNAL_IRQ_MASK = 6'h1D;
  localparam logic [5:0] GENERAL_SCRATCH_ZERO = 6'h1E;
  localparam logic [5:0] EEPROM_CONTROL = 6'h1F;
  localparam logic [5:0] EEPROM_DATA = 6'h20;
  localparam logic [5:0] EEPROM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] EEPROM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] TIMER_PRESCALER_CONTROL = 6'h23;
  localparam logic [5:0] TIMER_ZERO_CONTROL = 6'h24;
  localparam logic [5:0] TIMER_ZERO_COUNT = 6'h26;

  // Implemented-bit masks; bits outside a mask are reserved.
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_PORT_G_PINS = 8'h3F;
  localparam logic [7:0] MASK_PORT_G_CTRL = 8'h1F;
  localparam logic [7:0] MASK_TIMER_ZERO = 8'h03;
  localparam logic [7:0] MASK_TIMER_ONE = 8'h27;
  localparam logic [7:0] MASK_TIMER_TWO = 8'h03;
  localparam logic [7:0] MASK_EXT_IRQ = 8'hF1;
  localparam logic [7:0] MASK_EEPROM_CTRL = 8'h0F;
  localparam logic [7:0] MASK_EEPROM_ADDR_HIGH = 8'h07;
  localparam logic [7:0] MASK_PRESCALER = 8'h83;

  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] BIT_ONE = 8'h01;

  typedef enum logic [3:0] {
    NO_INSTR = 4'h0,
    IO_IN_INSTR = 4'h1,
    IO_OUT_INSTR = 4'h2,
    SET_SINGLE_BIT_INSTR = 4'h3,
    CLEAR_SINGLE_BIT_INSTR = 4'h4,
    SKIP_IF_BIT_SET_INSTR = 4'h5,
    SKIP_IF_BIT_CLEAR_INSTR = 4'h6,
    INDIRECT_LOAD_INSTR = 4'h7,
    DIRECT_LOAD_INSTR = 4'h8,
    DISPLACED_LOAD_INSTR = 4'h9,
    INDIRECT_STORE_INSTR = 4'hA,
    DIRECT_STORE_INSTR = 4'hB
  } op_t;

  typedef enum logic [1:0] {
    KIND_NONE = 2'b00,
    KIND_RW = 2'b01,
    KIND_RO = 2'b10,
    KIND_W1C = 2'b11
  } kind_t;

endpackage

// File: logic/io_space_register_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - Set and clear single-bit instructions change one addressed bit of any read-write register at I/O address 0x00 to 0x1F.
// - Skip-if-bit-set and skip-if-bit-clear instructions test one selected bit of a register in that same range.
// - A single-bit set or clear touches only the named bit, so other flags in that register change only when their own events raise them.
// - Writing a one to a status flag clears it unless the flag is raised again in the same cycle; writing a zero leaves it unchanged.
// - Short-form in and out instructions reach I/O addresses 0x00 to 0x3F, a space of 64 locations.
// - A load or store at data address I/O address plus 0x20 reaches the same physical register.
// - Loads and stores at data addresses 0x60 to 0xFF complete without error; loads return zero and stores are dropped.
module io_space_register_decoder (
  input wire clock_i,
  input wire rst_i,
  input wire clk_en_i,
  input io_space_pkg::op_t op_i,
  input wire [7:0] addr_i,
  input wire [2:0] bit_sel_i,
  input wire [7:0] wdata_i,
  input wire [7:0] port_a_pins_i,
  input wire [7:0] port_b_pins_i,
  input wire [7:0] port_c_pins_i,
  input wire [7:0] port_d_pins_i,
  input wire [7:0] port_e_pins_i,
  input wire [7:0] port_f_pins_i,
  input wire [7:0] port_g_pins_i,
  input wire [7:0] timer_zero_evt_i,
  input wire [7:0] timer_one_evt_i,
  input wire [7:0] timer_two_evt_i,
  input wire [7:0] external_irq_evt_i,
  output logic [7:0] rdata_o,
  output logic skip_o,
  output logic done_o,
  output logic access_err_o,
  output logic [7:0] port_a_dir_o,
  output logic [7:0] port_a_out_o,
  output logic [7:0] port_b_dir_o,
  output logic [7:0] port_b_out_o,
  output logic [7:0] port_c_dir_o,
  output logic [7:0] port_c_out_o,
  output logic [7:0] port_d_dir_o,
  output logic [7:0] port_d_out_o,
  output logic [7:0] port_e_dir_o,
  output logic [7:0] port_e_out_o,
  output logic [7:0] port_f_dir_o,
  output logic [7:0] port_f_out_o,
  output logic [7:0] port_g_dir_o,
  output logic [7:0] port_g_out_o,
  output logic [7:0] timer_zero_flags_o,
  output logic [7:0] timer_one_flags_o,
  output logic [7:0] timer_two_flags_o,
  output logic [7:0] external_irq_flags_o,
  output logic [7:0] external_irq_mask_o,
  output logic [7:0] scratch_o,
  output logic [7:0] eeprom_control_o,
  output logic [7:0] eeprom_data_o,
  output logic [7:0] eeprom_addr_low_o,
  output logic [7:0] eeprom_addr_high_o,
  output logic [7:0] prescaler_control_o,
  output logic [7:0] timer_zero_control_o,
  output logic [7:0] timer_zero_count_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register map lookups.

  function automatic io_space_pkg::kind_t reg_kind(input logic [5:0] idx);
    unique case (idx)
      io_space_pkg::PORT_A_INPUT_PINS, io_space_pkg::PORT_B_INPUT_PINS,
      io_space_pkg::PORT_C_INPUT_PINS, io_space_pkg::PORT_D_INPUT_PINS,
      io_space_pkg::PORT_E_INPUT_PINS, io_space_pkg::PORT_F_INPUT_PINS,
      io_space_pkg::PORT_G_INPUT_PINS: reg_kind = io_space_pkg::KIND_RO;
      io_space_pkg::TIMER_ZERO_FLAGS, io_space_pkg::TIMER_ONE_FLAGS,
      io_space_pkg::TIMER_TWO_FLAGS, io_space_pkg::EXTERNAL_IRQ_FLAGS: reg_kind = io_space_pkg::KIND_W1C;
      io_space_pkg::PORT_A_DIRECTION, io_space_pkg::PORT_A_OUTPUT,
      io_space_pkg::PORT_B_DIRECTION, io_space_pkg::PORT_B_OUTPUT,
      io_space_pkg::PORT_C_DIRECTION, io_space_pkg::PORT_C_OUTPUT,
      io_space_pkg::PORT_D_DIRECTION, io_space_pkg::PORT_D_OUTPUT,
      io_space_pkg::PORT_E_DIRECTION, io_space_pkg::PORT_E_OUTPUT,
      io_space_pkg::PORT_F_DIRECTION, io_space_pkg::PORT_F_OUTPUT,
      io_space_pkg::PORT_G_DIRECTION, io_space_pkg::PORT_G_OUTPUT,
      io_space_pkg::EXTERNAL_IRQ_MASK, io_space_pkg::GENERAL_SCRATCH_ZERO,
      io_space_pkg::EEPROM_CONTROL, io_space_pkg::EEPROM_DATA,
      io_space_pkg::EEPROM_ADDRESS_LOW, io_space_pkg::EEPROM_ADDRESS_HIGH,
      io_space_pkg::TIMER_PRESCALER_CONTROL, io_space_pkg::TIMER_ZERO_CONTROL,
      io_space_pkg::TIMER_ZERO_COUNT: reg_kind = io_space_pkg::KIND_RW;
      default: reg_kind = io_space_pkg::KIND_NONE;
    endcase
  endfunction

  function automatic logic [7:0] reg_mask(input logic [5:0] idx);
    unique case (idx)
      io_space_pkg::PORT_G_INPUT_PINS: reg_mask = io_space_pkg::MASK_PORT_G_PINS;
      io_space_pkg::PORT_G_DIRECTION, io_space_pkg::PORT_G_OUTPUT: reg_mask = io_space_pkg::MASK_PORT_G_CTRL;
      io_space_pkg::TIMER_ZERO_FLAGS: reg_mask = io_space_pkg::MASK_TIMER_ZERO;
      io_space_pkg::TIMER_ONE_FLAGS: reg_mask = io_space_pkg::MASK_TIMER_ONE;
      io_space_pkg::TIMER_TWO_FLAGS: reg_mask = io_space_pkg::MASK_TIMER_TWO;
      io_space_pkg::EXTERNAL_IRQ_FLAGS, io_space_pkg::EXTERNAL_IRQ_MASK: reg_mask = io_space_pkg::MASK_EXT_IRQ;
      io_space_pkg::EEPROM_CONTROL: reg_mask = io_space_pkg::MASK_EEPROM_CTRL;
      io_space_pkg::EEPROM_ADDRESS_HIGH: reg_mask = io_space_pkg::MASK_EEPROM_ADDR_HIGH;
      io_space_pkg::TIMER_PRESCALER_CONTROL: reg_mask = io_space_pkg::MASK_PRESCALER;
      default: reg_mask = (reg_kind(idx) == io_space_pkg::KIND_NONE) ? io_space_pkg::MASK_NONE
                                                                     : io_space_pkg::MASK_FULL;
    endcase
  endfunction

  function automatic logic [2:0] pin_port(input logic [5:0] idx);
    unique case (idx)
      io_space_pkg::PORT_B_INPUT_PINS: pin_port = 3'h1;
      io_space_pkg::PORT_C_INPUT_PINS: pin_port = 3'h2;
      io_space_pkg::PORT_D_INPUT_PINS: pin_port = 3'h3;
      io_space_pkg::PORT_E_INPUT_PINS: pin_port = 3'h4;
      io_space_pkg::PORT_F_INPUT_PINS: pin_port = 3'h5;
      io_space_pkg::PORT_G_INPUT_PINS: pin_port = 3'h6;
      default: pin_port = 3'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second.

  logic [7:0] pins_in [0:io_space_pkg::NUM_PORTS-1];
  logic [7:0] pin_meta_reg [0:io_space_pkg::NUM_PORTS-1];
  logic [7:0] pin_sync_reg [0:io_space_pkg::NUM_PORTS-1];

  always_comb begin
    pins_in[0] = port_a_pins_i;
    pins_in[1] = port_b_pins_i;
    pins_in[2] = port_c_pins_i;
    pins_in[3] = port_d_pins_i;
    pins_in[4] = port_e_pins_i;
    pins_in[5] = port_f_pins_i;
    pins_in[6] = port_g_pins_i;
  end

  always_ff @(posedge clock_i) begin
    for (int p = 0; p < io_space_pkg::NUM_PORTS; p++) begin
      if (rst_i) begin
        pin_meta_reg[p] <= io_space_pkg::RESET_VALUE;
        pin_sync_reg[p] <= io_space_pkg::RESET_VALUE;
      end else if (clk_en_i) begin
        pin_meta_reg[p] <= pins_in[p];
        pin_sync_reg[p] <= pin_meta_reg[p];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode.

  logic [5:0] io_idx;
  logic [7:0] data_rel;
  logic hit_io;
  logic is_read;
  logic is_write;
  logic is_bit;
  logic is_bit_code;
  logic refused;
  io_space_pkg::kind_t cur_kind;
  logic [7:0] cur_mask;
  logic [7:0] wen;
  logic [7:0] wd;
  logic [7:0] wr_masked;
  logic write_go;
  logic cur_bit;

  assign data_rel = addr_i - io_space_pkg::DATA_IO_OFFSET;

  always_comb begin
    io_idx = '0;
    hit_io = 1'b0;
    is_read = 1'b0;
    is_write = 1'b0;
    is_bit = 1'b0;
    is_bit_code = 1'b0;
    refused = 1'b0;
    unique case (op_i)
      io_space_pkg::NO_INSTR: begin
      end
      io_space_pkg::IO_IN_INSTR, io_space_pkg::IO_OUT_INSTR: begin
        if (addr_i <= io_space_pkg::SHORT_LAST) begin
          io_idx = addr_i[5:0];
          hit_io = 1'b1;
          is_read = (op_i == io_space_pkg::IO_IN_INSTR);
          is_write = (op_i == io_space_pkg::IO_OUT_INSTR);
        end else begin
          refused = 1'b1;
        end
      end
      io_space_pkg::SET_SINGLE_BIT_INSTR, io_space_pkg::CLEAR_SINGLE_BIT_INSTR,
      io_space_pkg::SKIP_IF_BIT_SET_INSTR, io_space_pkg::SKIP_IF_BIT_CLEAR_INSTR: begin
        is_bit_code = 1'b1;
        if (addr_i <= io_space_pkg::BIT_OP_LAST) begin
          io_idx = addr_i[5:0];
          hit_io = 1'b1;
          is_bit = 1'b1;
          is_write = (op_i == io_space_pkg::SET_SINGLE_BIT_INSTR) ||
                     (op_i == io_space_pkg::CLEAR_SINGLE_BIT_INSTR);
        end else begin
          refused = 1'b1;
        end
      end
      io_space_pkg::INDIRECT_LOAD_INSTR, io_space_pkg::DIRECT_LOAD_INSTR,
      io_space_pkg::DISPLACED_LOAD_INSTR, io_space_pkg::INDIRECT_STORE_INSTR,
      io_space_pkg::DIRECT_STORE_INSTR: begin
        if (addr_i >= io_space_pkg::DATA_IO_OFFSET && addr_i < io_space_pkg::EXT_FIRST) begin
          io_idx = data_rel[5:0];
          hit_io = 1'b1;
          is_read = (op_i == io_space_pkg::INDIRECT_LOAD_INSTR) ||
                    (op_i == io_space_pkg::DIRECT_LOAD_INSTR) ||
                    (op_i == io_space_pkg::DISPLACED_LOAD_INSTR);
          is_write = !is_read;
        end else if (addr_i < io_space_pkg::DATA_IO_OFFSET) begin
          // The working registers live below the I/O mirror and belong to the core.
          refused = 1'b1;
        end
      end
      default: refused = 1'b1;
    endcase
  end

  assign cur_kind = reg_kind(io_idx);
  assign cur_mask = reg_mask(io_idx);

  // Bit instructions carry a one-hot enable so no neighbouring bit is written.
  always_comb begin
    if (is_bit) begin
      wen = io_space_pkg::BIT_ONE << bit_sel_i;
      wd = (op_i == io_space_pkg::SET_SINGLE_BIT_INSTR) ? io_space_pkg::MASK_FULL : io_space_pkg::MASK_NONE;
    end else begin
      wen = io_space_pkg::MASK_FULL;
      wd = wdata_i;
    end
  end

  assign wr_masked = wd & wen & cur_mask;
  assign write_go = clk_en_i && hit_io && is_write && (cur_kind != io_space_pkg::KIND_NONE);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage, indexed by I/O address.

  logic [7:0] regs_reg [0:io_space_pkg::IO_SPACE_SIZE-1];
  logic [7:0] evt_by_idx [0:io_space_pkg::IO_SPACE_SIZE-1];

  always_comb begin
    for (int k = 0; k < io_space_pkg::IO_SPACE_SIZE; k++) begin
      evt_by_idx[k] = io_space_pkg::MASK_NONE;
    end
    evt_by_idx[io_space_pkg::TIMER_ZERO_FLAGS] = timer_zero_evt_i;
    evt_by_idx[io_space_pkg::TIMER_ONE_FLAGS] = timer_one_evt_i;
    evt_by_idx[io_space_pkg::TIMER_TWO_FLAGS] = timer_two_evt_i;
    evt_by_idx[io_space_pkg::EXTERNAL_IRQ_FLAGS] = external_irq_evt_i;
  end

  assign cur_bit = regs_reg[io_idx][bit_sel_i];

  always_ff @(posedge clock_i) begin
    for (int i = 0; i < io_space_pkg::IO_SPACE_SIZE; i++) begin
      if (rst_i) begin
        regs_reg[i] <= io_space_pkg::RESET_VALUE;
      end else if (clk_en_i) begin
        unique case (reg_kind(6'(i)))
          io_space_pkg::KIND_RO: begin
            regs_reg[i] <= pin_sync_reg[pin_port(6'(i))] & reg_mask(6'(i));
          end
          io_space_pkg::KIND_RW: begin
            if (write_go && io_idx == 6'(i)) begin
              regs_reg[i] <= (regs_reg[i] & ~(wen & cur_mask)) | wr_masked;
            end
          end
          io_space_pkg::KIND_W1C: begin
            // A flag raised in the same cycle as its clear survives the clear.
            if (write_go && io_idx == 6'(i)) begin
              regs_reg[i] <= (regs_reg[i] & ~wr_masked) | (evt_by_idx[i] & reg_mask(6'(i)));
            end else begin
              regs_reg[i] <= regs_reg[i] | (evt_by_idx[i] & reg_mask(6'(i)));
            end
          end
          io_space_pkg::KIND_NONE: begin
            regs_reg[i] <= io_space_pkg::RESET_VALUE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answer to the core, one cycle after the request.

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= io_space_pkg::RESET_VALUE;
      skip_o <= 1'b0;
      done_o <= 1'b0;
      access_err_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o <= (op_i != io_space_pkg::NO_INSTR);
      access_err_o <= refused || (hit_io && is_write && cur_kind == io_space_pkg::KIND_NONE);
      if (hit_io && is_read) begin
        rdata_o <= regs_reg[io_idx] & cur_mask;
      end else begin
        rdata_o <= io_space_pkg::RESET_VALUE;
      end
      if (is_bit && op_i == io_space_pkg::SKIP_IF_BIT_SET_INSTR) begin
        skip_o <= cur_bit;
      end else if (is_bit && op_i == io_space_pkg::SKIP_IF_BIT_CLEAR_INSTR) begin
        skip_o <= !cur_bit;
      end else begin
        skip_o <= 1'b0;
      end
    end
  end

  assign port_a_dir_o = regs_reg[io_space_pkg::PORT_A_DIRECTION];
  assign port_a_out_o = regs_reg[io_space_pkg::PORT_A_OUTPUT];
  assign port_b_dir_o = regs_reg[io_space_pkg::PORT_B_DIRECTION];
  assign port_b_out_o = regs_reg[io_space_pkg::PORT_B_OUTPUT];
  assign port_c_dir_o = regs_reg[io_space_pkg::PORT_C_DIRECTION];
  assign port_c_out_o = regs_reg[io_space_pkg::PORT_C_OUTPUT];
  assign port_d_dir_o = regs_reg[io_space_pkg::PORT_D_DIRECTION];
  assign port_d_out_o = regs_reg[io_space_pkg::PORT_D_OUTPUT];
  assign port_e_dir_o = regs_reg[io_space_pkg::PORT_E_DIRECTION];
  assign port_e_out_o = regs_reg[io_space_pkg::PORT_E_OUTPUT];
  assign port_f_dir_o = regs_reg[io_space_pkg::PORT_F_DIRECTION];
  assign port_f_out_o = regs_reg[io_space_pkg::PORT_F_OUTPUT];
  assign port_g_dir_o = regs_reg[io_space_pkg::PORT_G_DIRECTION];
  assign port_g_out_o = regs_reg[io_space_pkg::PORT_G_OUTPUT];
  assign timer_zero_flags_o = regs_reg[io_space_pkg::TIMER_ZERO_FLAGS];
  assign timer_one_flags_o = regs_reg[io_space_pkg::TIMER_ONE_FLAGS];
  assign timer_two_flags_o = regs_reg[io_space_pkg::TIMER_TWO_FLAGS];
  assign external_irq_flags_o = regs_reg[io_space_pkg::EXTERNAL_IRQ_FLAGS];
  assign external_irq_mask_o = regs_reg[io_space_pkg::EXTERNAL_IRQ_MASK];
  assign scratch_o = regs_reg[io_space_pkg::GENERAL_SCRATCH_ZERO];
  assign eeprom_control_o = regs_reg[io_space_pkg::EEPROM_CONTROL];
  assign eeprom_data_o = regs_reg[io_space_pkg::EEPROM_DATA];
  assign eeprom_addr_low_o = regs_reg[io_space_pkg::EEPROM_ADDRESS_LOW];
  assign eeprom_addr_high_o = regs_reg[io_space_pkg::EEPROM_ADDRESS_HIGH];
  assign prescaler_control_o = regs_reg[io_space_pkg::TIMER_PRESCALER_CONTROL];
  assign timer_zero_control_o = regs_reg[io_space_pkg::TIMER_ZERO_CONTROL];
  assign timer_zero_count_o = regs_reg[io_space_pkg::TIMER_ZERO_COUNT];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks. Helper state snapshots the target of each write for the next cycle.

  logic chk_bit_reg;
  logic chk_w1c_reg;
  logic [5:0] chk_idx_reg;
  logic [7:0] chk_prev_reg;
  logic [7:0] chk_keep_reg;
  logic [7:0] chk_clr_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      chk_bit_reg <= 1'b0;
      chk_w1c_reg <= 1'b0;
      chk_idx_reg <= '0;
      chk_prev_reg <= io_space_pkg::RESET_VALUE;
      chk_keep_reg <= io_space_pkg::RESET_VALUE;
      chk_clr_reg <= io_space_pkg::RESET_VALUE;
    end else begin
      chk_bit_reg <= write_go && is_bit && cur_kind == io_space_pkg::KIND_RW;
      chk_w1c_reg <= write_go && cur_kind == io_space_pkg::KIND_W1C;
      chk_idx_reg <= io_idx;
      chk_prev_reg <= regs_reg[io_idx];
      chk_keep_reg <= (cur_kind == io_space_pkg::KIND_W1C) ? (~(wd & wen) & ~evt_by_idx[io_idx]) : ~wen;
      chk_clr_reg <= wr_masked & ~evt_by_idx[io_idx];
    end
  end

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence s_bit_op_in_range;
    clk_en_i && hit_io && is_bit;
  endsequence

  sequence s_mirror_store;
    clk_en_i && hit_io && is_write && !is_bit && addr_i >= io_space_pkg::DATA_IO_OFFSET &&
      cur_kind == io_space_pkg::KIND_RW;
  endsequence

  a_bit_range_guard: assert property (clk_en_i && is_bit_code && addr_i > io_space_pkg::BIT_OP_LAST
    |=> access_err_o && !skip_o) else $error("bit op above bit range not refused");
  a_skip_bit_value: assert property (s_bit_op_in_range ##0 op_i == io_space_pkg::SKIP_IF_BIT_SET_INSTR
    |=> skip_o == $past(cur_bit)) else $error("skip result differs from tested bit");
  a_bit_op_isolated: assert property (chk_bit_reg
    |-> ((regs_reg[chk_idx_reg] ^ chk_prev_reg) & chk_keep_reg) == 8'h00)
    else $error("single bit op changed another bit");
  a_flag_zero_keeps: assert property (chk_w1c_reg
    |-> ((regs_reg[chk_idx_reg] ^ chk_prev_reg) & chk_keep_reg) == 8'h00)
    else $error("flag changed without a one written");
  a_flag_one_clears: assert property (chk_w1c_reg |-> (regs_reg[chk_idx_reg] & chk_clr_reg) == 8'h00)
    else $error("flag written with one not cleared");
  a_short_range: assert property (clk_en_i && addr_i > io_space_pkg::SHORT_LAST
    && (op_i == io_space_pkg::IO_IN_INSTR || op_i == io_space_pkg::IO_OUT_INSTR)
    |=> access_err_o && rdata_o == 8'h00) else $error("short form beyond 0x3F not refused");
  a_mirror_store: assert property (s_mirror_store |=> regs_reg[$past(io_idx)] == $past(wr_masked))
    else $error("store did not reach mirrored register");
  a_ext_load_zero: assert property (clk_en_i && op_i == io_space_pkg::DIRECT_LOAD_INSTR
    && addr_i >= io_space_pkg::EXT_FIRST |=> done_o && !access_err_o && rdata_o == 8'h00)
    else $error("extended load answer wrong");
  a_reserved_read: assert property (clk_en_i && hit_io && is_read && cur_kind == io_space_pkg::KIND_NONE
    |=> rdata_o == 8'h00) else $error("reserved address read nonzero");
  a_reset_default: assert property ($fell(rst_i) |-> port_a_out_o == 8'h00 && timer_zero_flags_o == 8'h00
    && !done_o) else $error("register not at default after reset");

endmodule

// File: tb/core_model.sv
`timescale 1ns/1ps
module core_model (
  input wire clock_i,
  output io_space_pkg::op_t op_o,
  output logic [7:0] addr_o,
  output logic [2:0] bit_sel_o,
  output logic [7:0] wdata_o
);
  initial begin
    op_o = io_space_pkg::NO_INSTR;
    addr_o = 8'h00;
    bit_sel_o = 3'h0;
    wdata_o = 8'h00;
  end
  // Reserved places are written only where a test asks for a refusal.
  task automatic issue(input io_space_pkg::op_t o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d);
    @(posedge clock_i);
    op_o <= o;
    addr_o <= a;
    bit_sel_o <= b;
    wdata_o <= d;
    @(posedge clock_i);
    op_o <= io_space_pkg::NO_INSTR;
    // Released address and data lines flip, so a stale value is never mistaken for a held one.
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask
endmodule

// File: tb/io_space_register_decoder_tb.sv
`timescale 1ns/1ps
module io_space_register_decoder_tb;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic clk_en_i = 1'b1;
  logic [7:0] pins = 8'h00;
  logic [7:0] evt = 8'h00;
  io_space_pkg::op_t op;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] bit_sel;
  logic skip, done, err;
  logic [7:0] pa_out, t0_flags, ext_flags, pg_out;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  always #25 clock_i = ~clock_i;
  core_model u_core (.clock_i(clock_i), .op_o(op), .addr_o(addr), .bit_sel_o(bit_sel), .wdata_o(wdata));
  io_space_register_decoder u_dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en_i), .op_i(op),
    .addr_i(addr), .bit_sel_i(bit_sel), .wdata_i(wdata), .port_a_pins_i(pins), .port_b_pins_i(pins),
    .port_c_pins_i(pins), .port_d_pins_i(pins), .port_e_pins_i(pins), .port_f_pins_i(pins),
    .port_g_pins_i(pins), .timer_zero_evt_i(evt), .timer_one_evt_i(evt), .timer_two_evt_i(evt),
    .external_irq_evt_i(evt), .rdata_o(rdata), .skip_o(skip), .done_o(done), .access_err_o(err),
    .port_a_dir_o(), .port_a_out_o(pa_out), .port_b_dir_o(), .port_b_out_o(), .port_c_dir_o(), .port_c_out_o(),
    .port_d_dir_o(), .port_d_out_o(), .port_e_dir_o(), .port_e_out_o(), .port_f_dir_o(), .port_f_out_o(),
    .port_g_dir_o(), .port_g_out_o(pg_out), .timer_zero_flags_o(t0_flags), .timer_one_flags_o(),
    .timer_two_flags_o(), .external_irq_flags_o(ext_flags), .external_irq_mask_o(), .scratch_o(),
    .eeprom_control_o(), .eeprom_data_o(),
    .eeprom_addr_low_o(), .eeprom_addr_high_o(), .prescaler_control_o(), .timer_zero_control_o(),
    .timer_zero_count_o());
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // The expected word is {error, skip, read data}; done must be high for every request.
  task automatic io(input io_space_pkg::op_t o, input logic [7:0] a, input logic [2:0] b, input logic [7:0] d,
    input logic [9:0] exp);
    u_core.issue(o, a, b, d);
    chk({done, err, skip, rdata}, {1'b1, exp});
  endtask
  task automatic bit_test(input io_space_pkg::op_t o, input logic [2:0] b, input logic exp);
    u_core.issue(o, 8'h02, b, 8'h00);
    chk({10'h000, skip}, {10'h000, exp});
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (12) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      io(io_space_pkg::IO_IN_INSTR, 8'(i), 3'h0, 8'h00, 10'h000);
    end
    io(io_space_pkg::IO_OUT_INSTR, 8'h02, 3'h0, 8'h5A, 10'h000);
    io(io_space_pkg::DIRECT_LOAD_INSTR, 8'h22, 3'h0, 8'h00, 10'h05A);
    io(io_space_pkg::DIRECT_STORE_INSTR, 8'h21, 3'h0, 8'hA5, 10'h000);
    io(io_space_pkg::IO_IN_INSTR, 8'h01, 3'h0, 8'h00, 10'h0A5);
    io(io_space_pkg::SET_SINGLE_BIT_INSTR, 8'h02, 3'h0, 8'h00, 10'h000);
    io(io_space_pkg::CLEAR_SINGLE_BIT_INSTR, 8'h02, 3'h1, 8'h00, 10'h000);
    io(io_space_pkg::IO_IN_INSTR, 8'h02, 3'h0, 8'h00, 10'h059);
    chk({3'h0, pa_out}, {3'h0, 8'h59});
    @(posedge clock_i);
    clk_en_i <= 1'b0;
    u_core.issue(io_space_pkg::IO_OUT_INSTR, 8'h02, 3'h0, 8'h00);
    chk({2'h0, done, pa_out}, {3'h0, 8'h59});
    @(posedge clock_i);
    clk_en_i <= 1'b1;
    bit_test(io_space_pkg::SKIP_IF_BIT_SET_INSTR, 3'h0, 1'b1);
    bit_test(io_space_pkg::SKIP_IF_BIT_SET_INSTR, 3'h1, 1'b0);
    bit_test(io_space_pkg::SKIP_IF_BIT_CLEAR_INSTR, 3'h1, 1'b1);
    bit_test(io_space_pkg::SKIP_IF_BIT_CLEAR_INSTR, 3'h0, 1'b0);
    @(posedge clock_i);
    evt <= 8'hFF;
    @(posedge clock_i);
    evt <= 8'h00;
    io(io_space_pkg::IO_IN_INSTR, 8'h16, 3'h0, 8'h00, 10'h027);
    io(io_space_pkg::IO_OUT_INSTR, 8'h15, 3'h0, 8'h01, 10'h000);
    io(io_space_pkg::IO_IN_INSTR, 8'h15, 3'h0, 8'h00, 10'h002);
    chk({3'h0, t0_flags}, {3'h0, 8'h02});
    io(io_space_pkg::SET_SINGLE_BIT_INSTR, 8'h1C, 3'h4, 8'h00, 10'h000);
    io(io_space_pkg::CLEAR_SINGLE_BIT_INSTR, 8'h1C, 3'h0, 8'h00, 10'h000);
    io(io_space_pkg::IO_IN_INSTR, 8'h1C, 3'h0, 8'h00, 10'h0E1);
    chk({3'h0, ext_flags}, {3'h0, 8'hE1});
    io(io_space_pkg::IO_IN_INSTR, 8'h40, 3'h0, 8'h00, 10'h200);
    io(io_space_pkg::SET_SINGLE_BIT_INSTR, 8'h20, 3'h0, 8'h00, 10'h200);
    io(io_space_pkg::DIRECT_LOAD_INSTR, 8'h1F, 3'h0, 8'h00, 10'h200);
    io(io_space_pkg::DIRECT_STORE_INSTR, 8'h60, 3'h0, 8'h55, 10'h000);
    io(io_space_pkg::DIRECT_LOAD_INSTR, 8'h60, 3'h0, 8'h00, 10'h000);
    io(io_space_pkg::IO_OUT_INSTR, 8'h18, 3'h0, 8'hFF, 10'h200);
    io(io_space_pkg::IO_IN_INSTR, 8'h18, 3'h0, 8'h00, 10'h000);
    io(io_space_pkg::IO_OUT_INSTR, 8'h14, 3'h0, 8'hFF, 10'h000);
    io(io_space_pkg::IO_IN_INSTR, 8'h14, 3'h0, 8'h00, 10'h01F);
    chk({3'h0, pg_out}, {3'h0, 8'h1F});
    pins <= 8'hC3;
    repeat (4) @(posedge clock_i);
    io(io_space_pkg::DIRECT_LOAD_INSTR, 8'h23, 3'h0, 8'h00, 10'h0C3);
    io(io_space_pkg::IO_IN_INSTR, 8'h12, 3'h0, 8'h00, 10'h003);
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    io(io_space_pkg::IO_IN_INSTR, 8'h02, 3'h0, 8'h00, 10'h000);
    final_report();
  end
endmodule
